// >>> pllrb_top.sv
`timescale 1ns/100ps
// Functional notes
// - Port word: select, index, payload fields
// - Calibration updates only the payload field
// - Calibration never alters select or index
// - Each port write queues one transfer; a newer write replaces one not yet started
// - Index zero reads the part identity
// - Index zero write sets read pointer
// - Bit five soft-resets the host serial port and the read pointer, not the tuner link
// - Reference divider needs reference buffer on
// - Fraction applies in fractional mode only
// - Port read returns last transfer
// - Packets shift out MSB first
// - Link runs on calibration clock
// - Frame: data, index, chip; latched
module pllrb_top
  import pllrb_pkg::*;
#(
  // Value is arbitrary
  parameter logic [23:0] PART_IDENTITY = PART_IDENTITY_DEFAULT
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        sclk,
  input  wire logic        serial_enable,
  input  wire logic        serial_in,
  output logic             serial_out,
  input  wire logic        tuner_clk,
  output logic             tuner_link_en,
  output logic             tuner_link_data,
  input  wire logic        auto_calibration_write,
  input  wire logic [8:0]  auto_calibration_payload,
  input  wire logic        ref_buffer_on,
  input  wire logic        frac_mode,
  output logic [13:0]      ref_div_eff,
  output logic [18:0]      int_div,
  output logic [23:0]      frac_eff
);
  import pllrb_pkg::*;

  logic [1:0]   rst_sync_q;
  logic         rst_n;
  logic [1:0]   lvl_meta_q;
  logic [1:0]   lvl_sync_q;
  logic         refbuf_s;
  logic         fracm_s;

  pllrb_frame_t frame;
  logic         frame_valid;
  logic         host_wr;
  logic         soft_rst_q;

  logic [4:0]   rd_ptr_q;
  logic [23:0]  rd_data_q;
  logic [9:0]   rstctl_q;
  logic [13:0]  reference_divider_q;
  logic [18:0]  intg_q;
  logic [23:0]  frac_q;

  pllrb_pkt_t   port_q;
  pllrb_pkt_t   pend_pkt_q;
  pllrb_pkt_t   xfer_q;
  logic [15:0]  last_xfer_q;
  logic         pend_q;
  logic         req_tgl_q;
  logic [1:0]   ack_meta_q;
  logic         ack_raw;
  logic         ack_tgl;
  logic         busy;
  logic         launch;
  logic         fwd_wr;
  logic         cal_wr;
  pllrb_pkt_t   port_next;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // Mode levels from outside the clock domain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_meta_q <= 2'h0;
      lvl_sync_q <= 2'h0;
    end
    else
    begin
      lvl_meta_q <= {ref_buffer_on, frac_mode};
      lvl_sync_q <= lvl_meta_q;
    end
  end

  assign refbuf_s = lvl_sync_q[1];
  assign fracm_s  = lvl_sync_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Host serial port
  pllrb_spi_rx u_spi_rx (
    .clk           (clk),
    .rst_n         (rst_n),
    .soft_rst      (soft_rst_q),
    .sclk          (sclk),
    .serial_enable (serial_enable),
    .serial_in     (serial_in),
    .rd_data       (rd_data_q),
    .frame         (frame),
    .frame_valid   (frame_valid),
    .serial_out    (serial_out)
  );

  // Frames for other chip addresses are ignored
  assign host_wr = frame_valid && (frame.chip == CHIP_ADDR);

  function automatic logic wr_to(input logic [4:0] idx);
    wr_to = host_wr && (frame.index == idx);
  endfunction : wr_to

  ////////////////////////////////////////////////////////////////////////////
  // Read pointer and soft reset strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr_q   <= RD_PTR_RESET;
      soft_rst_q <= 1'b0;
    end
    else
    begin
      soft_rst_q <= wr_to(REG_IDENT) && frame.data[SOFT_RST_BIT];
      if (wr_to(REG_IDENT) && frame.data[SOFT_RST_BIT])
        rd_ptr_q <= RD_PTR_RESET;
      else if (wr_to(REG_IDENT))
        rd_ptr_q <= frame.data[RD_PTR_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstctl_q <= RSTCTL_RESET;
      reference_divider_q <= REFERENCE_DIVIDER_RESET;
      intg_q   <= INTG_RESET;
      frac_q   <= FRAC_RESET;
    end
    else
    begin
      if (wr_to(REG_RSTCTL))
        rstctl_q <= frame.data[9:0];
      if (wr_to(REG_REFERENCE_DIVIDER))
        reference_divider_q <= frame.data[13:0];
      if (wr_to(REG_INTG))
        intg_q <= frame.data[18:0];
      if (wr_to(REG_FRAC))
        frac_q <= frame.data;
    end
  end

  // Read mux, registered so the shifter sees a stable word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_q <= 24'h0;
    else
    begin
      case (rd_ptr_q)
        REG_IDENT:  rd_data_q <= PART_IDENTITY;
        REG_RSTCTL: rd_data_q <= {14'h0, rstctl_q};
        REG_REFERENCE_DIVIDER: rd_data_q <= {10'h0, reference_divider_q};
        REG_INTG:   rd_data_q <= {5'h0, intg_q};
        REG_FRAC:   rd_data_q <= frac_q;
        REG_FWD:    rd_data_q <= {8'h0, last_xfer_q};
        default:    rd_data_q <= 24'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective divider values for the synthesizer core
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_div_eff <= REFERENCE_DIVIDER_RESET;
      int_div     <= INTG_RESET;
      frac_eff    <= FRAC_RESET;
    end
    else
    begin
      ref_div_eff <= refbuf_s ? reference_divider_q : REFERENCE_DIVIDER_RESET;
      int_div     <= intg_q;
      frac_eff    <= fracm_s ? frac_q : FRAC_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forward port: host writes the whole word, calibration only the payload
  assign fwd_wr = wr_to(REG_FWD);
  assign cal_wr = auto_calibration_write && !fwd_wr;

  always_comb
  begin
    port_next = port_q;
    if (fwd_wr)
      port_next = pllrb_pkt_t'(frame.data[15:0]);
    else if (cal_wr)
      port_next.subsystem_payload = auto_calibration_payload;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      port_q <= pllrb_pkt_t'(FWD_RESET);
    else
      port_q <= port_next;
  end

  // One pending slot; a newer write replaces a packet not yet started
  assign busy   = req_tgl_q != ack_tgl;
  assign launch = pend_q && !busy;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_q     <= 1'b0;
      pend_pkt_q <= pllrb_pkt_t'(FWD_RESET);
    end
    else if (fwd_wr || auto_calibration_write)
    begin
      pend_q     <= 1'b1;
      pend_pkt_q <= port_next;
    end
    else if (launch)
      pend_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_tgl_q   <= 1'b0;
      xfer_q      <= pllrb_pkt_t'(FWD_RESET);
      last_xfer_q <= FWD_RESET;
    end
    else if (launch)
    begin
      req_tgl_q   <= ~req_tgl_q;
      xfer_q      <= pend_pkt_q;
      last_xfer_q <= pend_pkt_q;
    end
  end

  // Acknowledge toggle back from the link domain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_meta_q <= 2'h0;
    else
      ack_meta_q <= {ack_meta_q[0], ack_raw};
  end

  assign ack_tgl = ack_meta_q[1];

  pllrb_tuner_link u_link (
    .tuner_clk (tuner_clk),
    .rst_n     (rst_n),
    .req_tgl   (req_tgl_q),
    .pkt       (xfer_q),
    .ack_tgl   (ack_raw),
    .link_en   (tuner_link_en),
    .link_data (tuner_link_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_fwd_written;
    fwd_wr ##1 pend_q;
  endsequence

  a_port_fields: assert property (fwd_wr |=> pend_pkt_q == $past(frame.data[15:0]))
    else $error("port word not split into select, index and payload");

  a_cal_fields: assert property (cal_wr |=> port_q[6:0] == $past(port_q[6:0]))
    else $error("calibration altered select or index");

  a_cal_payload: assert property (cal_wr |=> port_q.subsystem_payload == $past(auto_calibration_payload))
    else $error("calibration payload not stored");

  a_write_starts: assert property (s_fwd_written |-> ##[0:400] launch)
    else $error("port write did not start a transfer");

  a_id_read: assert property (rd_ptr_q == REG_IDENT |=> rd_data_q == PART_IDENTITY)
    else $error("index zero did not return identity");

  // Write decode spelled out: a function body would not see sampled values
  a_read_ptr: assert property (host_wr && frame.index == REG_IDENT && !frame.data[SOFT_RST_BIT]
                               |=> rd_ptr_q == $past(frame.data[4:0]))
    else $error("read pointer not updated");

  a_soft_reset: assert property (host_wr && frame.index == REG_IDENT && frame.data[SOFT_RST_BIT]
                                 |=> soft_rst_q && rd_ptr_q == RD_PTR_RESET)
    else $error("soft reset not applied");

  a_refbuf_gate: assert property (!refbuf_s |=> ref_div_eff == REFERENCE_DIVIDER_RESET)
    else $error("reference divider used without buffer");

  a_frac_gate: assert property (!fracm_s |=> frac_eff == FRAC_RESET)
    else $error("fraction applied outside fractional mode");

  a_last_xfer: assert property (launch |=> last_xfer_q == $past(pend_pkt_q))
    else $error("readback is not the last transfer");

  // A whole packet takes many link clocks, so busy must outlast the launch
  a_one_at_time: assert property (launch |=> busy [*8])
    else $error("link freed before the packet could have finished");

endmodule : pllrb_top

// >>> pllrb_pkg.sv
package pllrb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, as carried in the 5-bit index field of a host frame
  localparam logic [4:0]  REG_IDENT     = 5'h00;
  localparam logic [4:0]  REG_RSTCTL    = 5'h01;
  localparam logic [4:0]  REG_REFERENCE_DIVIDER    = 5'h02;
  localparam logic [4:0]  REG_INTG      = 5'h03;
  localparam logic [4:0]  REG_FRAC      = 5'h04;
  localparam logic [4:0]  REG_FWD       = 5'h05;

  // Value is arbitrary, not tied to any real part
  localparam logic [23:0] PART_IDENTITY_DEFAULT = 24'h5a0c31;

  // Reset values
  localparam logic [9:0]  RSTCTL_RESET  = 10'h002;
  localparam logic [13:0] REFERENCE_DIVIDER_RESET  = 14'h0001;
  localparam logic [18:0] INTG_RESET    = 19'h00019;
  localparam logic [23:0] FRAC_RESET    = 24'h000000;
  localparam logic [15:0] FWD_RESET     = 16'h0000;
  localparam logic [4:0]  RD_PTR_RESET  = 5'h00;

  // Field positions inside the write word of the pointer register
  localparam int          RD_PTR_MSB    = 4;
  localparam int          SOFT_RST_BIT  = 5;

  // Only this chip address is answered
  localparam logic [2:0]  CHIP_ADDR     = 3'h0;

  // Internal link: last bit index of a 16-bit packet
  localparam logic [3:0]  PKT_LAST_BIT  = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Host frame in shift order: data first, index, then chip address
  typedef struct packed {
    logic [23:0] data;
    logic [4:0]  index;
    logic [2:0]  chip;
  } pllrb_frame_t;

  // Packet for the tuning subsystem
  typedef struct packed {
    logic [8:0]  subsystem_payload;
    logic [3:0]  subsystem_reg_index;
    logic [2:0]  subsystem_select;
  } pllrb_pkt_t;

endpackage : pllrb_pkg

// >>> pllrb_spi_rx.sv
`timescale 1ns/100ps
module pllrb_spi_rx
  import pllrb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   soft_rst,
  input  wire logic                   sclk,
  input  wire logic                   serial_enable,
  input  wire logic                   serial_in,
  input  wire logic [23:0]            rd_data,
  output pllrb_pkg::pllrb_frame_t     frame,
  output logic                        frame_valid,
  output logic                        serial_out
);
  import pllrb_pkg::*;

  logic [2:0]  meta_q;
  logic [2:0]  sync_q;
  logic [1:0]  prev_q;
  logic [31:0] in_sr_q;
  logic [23:0] out_sr_q;
  logic        sclk_rise;
  logic        sen_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from the host's clock domain; sclk must stay well below clk/4
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Enable idles high: start there so reset release is not taken as a latch edge
      meta_q <= 3'h2;
      sync_q <= 3'h2;
      prev_q <= 2'h1;
    end
    else
    begin
      meta_q <= {sclk, serial_enable, serial_in};
      sync_q <= meta_q;
      prev_q <= sync_q[2:1];
    end
  end

  assign sclk_rise = sync_q[2] & ~prev_q[1];
  assign sen_rise  = sync_q[1] & ~prev_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Frame shift, MSB first, latched on the rising edge of serial_enable
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_sr_q     <= 32'h0;
      frame       <= '0;
      frame_valid <= 1'b0;
    end
    else if (soft_rst)
    begin
      in_sr_q     <= 32'h0;
      frame_valid <= 1'b0;
    end
    else
    begin
      frame_valid <= sen_rise;
      if (sen_rise)
        frame <= pllrb_frame_t'(in_sr_q);
      if (sclk_rise && !sync_q[1])
        in_sr_q <= {in_sr_q[30:0], sync_q[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data reloads while enable is high, shifts out during the cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_sr_q   <= 24'h0;
      serial_out <= 1'b0;
    end
    else if (soft_rst)
    begin
      out_sr_q   <= 24'h0;
      serial_out <= 1'b0;
    end
    else
    begin
      if (sync_q[1])
        out_sr_q <= rd_data;
      else if (sclk_rise)
        out_sr_q <= {out_sr_q[22:0], 1'b0};
      serial_out <= out_sr_q[23];
    end
  end

endmodule : pllrb_spi_rx

// >>> pllrb_tuner_link.sv
`timescale 1ns/100ps
module pllrb_tuner_link
  import pllrb_pkg::*;
(
  input  wire logic                   tuner_clk,
  input  wire logic                   rst_n,
  input  wire logic                   req_tgl,
  input  pllrb_pkg::pllrb_pkt_t       pkt,
  output logic                        ack_tgl,
  output logic                        link_en,
  output logic                        link_data
);
  import pllrb_pkg::*;

  typedef enum logic [0:0] {LINK_IDLE, LINK_SHIFT} pllrb_link_st_t;

  pllrb_link_st_t st_q;
  logic [1:0]     trst_q;
  logic           lrst_n;
  logic [2:0]     req_q;
  logic [15:0]    sr_q;
  logic [3:0]     cnt_q;
  logic           start;

  ////////////////////////////////////////////////////////////////////////////
  // Local reset: asserts at once, releases on the link clock
  always_ff @(posedge tuner_clk or negedge rst_n)
  begin
    if (!rst_n)
      trst_q <= 2'h0;
    else
      trst_q <= {trst_q[0], 1'b1};
  end

  assign lrst_n = trst_q[1];

  // Request toggle crosses on two flops; packet is held stable until ack
  always_ff @(posedge tuner_clk or negedge lrst_n)
  begin
    if (!lrst_n)
      req_q <= 3'h0;
    else
      req_q <= {req_q[1:0], req_tgl};
  end

  assign start = (st_q == LINK_IDLE) && (req_q[2] != req_q[1]);

  ////////////////////////////////////////////////////////////////////////////
  // Shifter runs on the calibration clock
  always_ff @(posedge tuner_clk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      st_q      <= LINK_IDLE;
      sr_q      <= 16'h0;
      cnt_q     <= 4'h0;
      ack_tgl   <= 1'b0;
      link_en   <= 1'b0;
      link_data <= 1'b0;
    end
    else
    begin
      case (st_q)
        LINK_IDLE:
        begin
          link_en   <= 1'b0;
          link_data <= 1'b0;
          if (start)
          begin
            sr_q  <= pkt;
            cnt_q <= 4'h0;
            st_q  <= LINK_SHIFT;
          end
        end
        LINK_SHIFT:
        begin
          link_en   <= 1'b1;
          link_data <= sr_q[15];
          sr_q      <= {sr_q[14:0], 1'b0};
          cnt_q     <= cnt_q + 4'h1;
          if (cnt_q == PKT_LAST_BIT)
          begin
            ack_tgl <= req_q[2];
            st_q    <= LINK_IDLE;
          end
        end
        default: st_q <= LINK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_first_bit;
    link_en && (link_data == $past(pkt[15], 1));
  endsequence

  property p_msb_first;
    @(posedge tuner_clk) disable iff (!lrst_n)
      start |=> ##1 s_first_bit;
  endproperty

  a_link_msb_first: assert property (p_msb_first)
    else $error("link did not send packet MSB first");

endmodule : pllrb_tuner_link

// >>> pllrb_host_model.sv
`timescale 1ns/100ps
module pllrb_host_model
  import pllrb_pkg::*;
(
  input  wire logic clk,
  output logic      sclk,
  output logic      serial_enable,
  output logic      serial_in,
  input  wire logic serial_out
);
  import pllrb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock rests low and enable rests high between frames
  initial
  begin
    sclk          = 1'b0;
    serial_enable = 1'b1;
    serial_in     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half period of 5 clk keeps sclk well inside the oversampling limit
  task automatic xfer(input pllrb_frame_t f, output logic [23:0] rd);
    logic [31:0] w;
    w = f;
    @(negedge clk);
    serial_enable = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      serial_in = w[i];
      repeat (5) @(negedge clk);
      if (i > 7)
        rd[i-8] = serial_out;
      sclk = 1'b1;
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
    // Line released: drive the inverse so a stale value cannot pass
    serial_in = ~w[0];
    repeat (2) @(negedge clk);
    serial_enable = 1'b1;
    repeat (10) @(negedge clk);
  endtask : xfer

endmodule : pllrb_host_model

// >>> pllrb_top_tb.sv
`timescale 1ns/100ps
module pllrb_top_tb;
  import pllrb_pkg::*;

  logic        clk;
  logic        nrst;
  logic        sclk;
  logic        serial_enable;
  logic        serial_in;
  logic        serial_out;
  logic        tuner_clk;
  logic        tuner_link_en;
  logic        tuner_link_data;
  logic        auto_calibration_write;
  logic [8:0]  auto_calibration_payload;
  logic        ref_buffer_on;
  logic        frac_mode;
  logic [13:0] ref_div_eff;
  logic [18:0] int_div;
  logic [23:0] frac_eff;
  int          bad_count = 0;
  int          samples_checked = 0;
  logic [15:0] exp_q[$];
  logic [15:0] lsh;
  int          lcnt = 0;

  localparam logic [4:0]  IDX [7] = '{REG_IDENT, REG_RSTCTL, REG_REFERENCE_DIVIDER, REG_INTG,
                                      REG_FRAC, REG_FWD, 5'h1f};
  localparam logic [23:0] RV  [7] = '{PART_IDENTITY_DEFAULT, 24'(RSTCTL_RESET),
                                      24'(REFERENCE_DIVIDER_RESET), 24'(INTG_RESET), FRAC_RESET,
                                      24'(FWD_RESET), 24'h000000};

  pllrb_top #(.PART_IDENTITY(PART_IDENTITY_DEFAULT)) dut (
    .clk(clk), .nrst(nrst), .sclk(sclk), .serial_enable(serial_enable),
    .serial_in(serial_in), .serial_out(serial_out), .tuner_clk(tuner_clk),
    .tuner_link_en(tuner_link_en), .tuner_link_data(tuner_link_data),
    .auto_calibration_write(auto_calibration_write), .auto_calibration_payload(auto_calibration_payload),
    .ref_buffer_on(ref_buffer_on), .frac_mode(frac_mode),
    .ref_div_eff(ref_div_eff), .int_div(int_div), .frac_eff(frac_eff));

  pllrb_host_model host (
    .clk(clk), .sclk(sclk), .serial_enable(serial_enable),
    .serial_in(serial_in), .serial_out(serial_out));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Link clock free-running, phase unrelated to clk
  initial
  begin
    tuner_clk = 1'b0;
    #17;
    forever #32 tuner_clk = ~tuner_clk;
  end

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop;
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [4:0] idx, input logic [23:0] d, input logic [2:0] ch,
                    output logic [23:0] rd);
    pllrb_frame_t f;
    f = '{data: d, index: idx, chip: ch};
    host.xfer(f, rd);
  endtask : wr

  // Pointer frame, then a repeat of it that carries the selected register out
  task automatic rd_reg(input logic [4:0] idx, output logic [23:0] v);
    wr(REG_IDENT, 24'(idx), 3'h0, v);
    wr(REG_IDENT, 24'(idx), 3'h0, v);
  endtask : rd_reg

  task automatic auto_calibration(input logic [8:0] p);
    @(negedge clk);
    auto_calibration_write   = 1'b1;
    auto_calibration_payload = p;
    @(negedge clk);
    auto_calibration_write   = 1'b0;
  endtask : auto_calibration

  ////////////////////////////////////////////////////////////////////////////
  // Link watcher: gathers one packet per enable burst
  always @(negedge tuner_clk)
  begin
    if (tuner_link_en === 1'b1)
    begin
      lsh = {lsh[14:0], tuner_link_data};
      lcnt++;
    end
    else if (lcnt != 0)
    begin
      check("link bit count", 24'd16, 24'(lcnt));
      if (exp_q.size() == 0)
        check("unexpected packet", 24'h0, 24'(lsh));
      else
        check("link packet", 24'(exp_q.pop_front()), 24'(lsh));
      lcnt = 0;
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [23:0] rv;
    logic [23:0] rdv;
    logic [23:0] itg;
    logic [23:0] frc;
    logic [7:0]  sw;
    logic [8:0]  ap;
    nrst            = 1'b0;
    auto_calibration_write   = 1'b0;
    auto_calibration_payload = 9'h000;
    ref_buffer_on   = 1'b0;
    frac_mode       = 1'b0;
    void'($urandom(11));
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    check("ref_div_eff reset", 24'h1, 24'(ref_div_eff));
    check("int_div reset", 24'(INTG_RESET), 24'(int_div));
    check("frac_eff reset", 24'h0, frac_eff);
    // Chained pointer writes: each frame returns the previous target
    for (int j = 0; j < 8; j++)
    begin
      wr(REG_IDENT, 24'(IDX[j % 7]), 3'h0, rv);
      if (j > 0)
        check("register reset value", RV[j-1], rv);
    end

    // Divider, integer and fraction values inside their legal ranges
    rdv = 24'(1 + $urandom % 16383);
    itg = 24'(20 + $urandom % 524265);
    frc = 24'($urandom);
    wr(REG_REFERENCE_DIVIDER, rdv, 3'h0, rv);
    wr(REG_INTG, itg, 3'h0, rv);
    wr(REG_FRAC, frc, 3'h0, rv);
    check("ref_div_eff gated", 24'h1, 24'(ref_div_eff));
    check("frac_eff gated", 24'h0, frac_eff);
    check("int_div", itg, 24'(int_div));
    ref_buffer_on = 1'b1;
    frac_mode     = 1'b1;
    repeat (6) @(negedge clk);
    check("ref_div_eff", rdv, 24'(ref_div_eff));
    check("frac_eff", frc, frac_eff);
    // Another chip address must be ignored
    wr(REG_INTG, 24'h000010, 3'h1, rv);
    rd_reg(REG_INTG, rv);
    check("int after foreign chip", itg, rv);

    // Manual subsystem reset keeps the switch settings, tune voltage off
    sw = 8'($urandom);
    exp_q.push_back({sw, 1'b0, 4'h0, 3'h0});
    wr(REG_FWD, {8'h00, sw, 1'b0, 4'h0, 3'h0}, 3'h0, rv);
    // Calibration lands while the link is busy and must be held
    ap = 9'($urandom);
    exp_q.push_back({ap, 4'h0, 3'h0});
    auto_calibration(ap);
    // Manual access with a nonzero index, then calibration keeps it
    exp_q.push_back(16'h7f10);
    wr(REG_FWD, 24'h007f10, 3'h0, rv);
    ap = 9'($urandom);
    exp_q.push_back({ap, 4'h2, 3'h0});
    auto_calibration(ap);
    rd_reg(REG_FWD, rv);
    check("forward port readback", {8'h00, ap, 4'h2, 3'h0}, rv);

    // Soft reset drops the pointer but keeps configuration
    wr(REG_IDENT, 24'h000020 | 24'(REG_INTG), 3'h0, rv);
    wr(REG_IDENT, 24'(REG_INTG), 3'h0, rv);
    check("pointer after soft reset", PART_IDENTITY_DEFAULT, rv);
    wr(REG_IDENT, 24'(REG_INTG), 3'h0, rv);
    check("int after soft reset", itg, rv);

    for (int k = 0; k < 400 && exp_q.size() != 0; k++)
      @(negedge clk);
    check("packets outstanding", 24'h0, 24'(exp_q.size()));
    report_and_stop();
  end

endmodule : pllrb_top_tb
